// File: logic/pmra_consts.svh
// pmra_consts.svh: offsets, field positions and reset values of the
// result and diagnostic register bank.
// assumes: included by bare name from every design module file of the bank.
//
// Summary of operation
// (R1) temperature in bits 15-4, low nibble zero
// (R2) current result is 16-bit two's complement
// (R3) power result is 24-bit unsigned value
// (R4) transparent mode: alert follows the condition
// (R5) latched mode: alert holds until diagnostic read
// (R6) bit 14 routes conversion-done flag to alert
// (R7) bit 13 compares averaged instead of raw
// (R8) bit 12 selects alert polarity, low/high
// (R9) reserved bits 11-10 and 8 read zero
// (R10) bit 9 flags arithmetic overflow
// (R11) overflow clears on trigger or accumulator clear
// (R12) bit 7 temperature over limit, read-clear latched
// (R13) bit 6 shunt over limit, read-clear latched
// (R14) bit 5 shunt under limit, read-clear latched
// (R15) bit 4 bus over limit, read-clear latched
// (R16) bit 3 bus under limit, read-clear latched
// (R17) bit 2 power over limit, read-clear latched
// (R18) bit 1 conversion done, read or trigger clears
// (R19) bit 0 resets one, zero on checksum error
// (R20) averaging on: results update after full sequence
// (R21) mode 1-7 triggered, 9-F continuous, 0/8 off
// (R22) alert drives active level only, else released
`ifndef PMRA_CONSTS_SVH
`define PMRA_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PMRA_OFS_TEMP     6'h06
`define PMRA_OFS_CURR     6'h07
`define PMRA_OFS_PWR      6'h08
`define PMRA_OFS_DIAG     6'h0b

// ----------------------------------------
// diagnostic and temperature register fields
// ----------------------------------------
`define PMRA_BIT_LATCH    15
`define PMRA_BIT_RDYALERT 14
`define PMRA_BIT_AVGCMP   13
`define PMRA_BIT_POLSEL   12
`define PMRA_BIT_OVF      9
`define PMRA_BIT_LIMLO    2
`define PMRA_BIT_DONE     1
`define PMRA_BIT_TRIMOK   0
`define PMRA_NUM_LIMITS   6
`define PMRA_TEMP_SHIFT   4

// ----------------------------------------
// reset values
// ----------------------------------------
`define PMRA_DIAG_RST     16'h0001
`define PMRA_RESULT_RST   24'h000000

`endif

// File: logic/pmra_pkg.sv
// pmra_pkg.sv: types shared by the result and diagnostic register bank.
// assumes: compiled before every module of the bank.
`default_nettype none

package pmra_pkg;

  // ----------------------------------------
  // operating mode classes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PMRA_MODE_OFF  = 2'b00,
    PMRA_MODE_TRIG = 2'b01,
    PMRA_MODE_CONT = 2'b10
  } pmra_mode_t;

  typedef logic [15:0] pmra_word_t;

endpackage

`default_nettype wire

// File: logic/pmra_event_flag.sv
// pmra_event_flag.sv: one diagnostic event flag with transparent and
// latched behaviour.
// assumes: strobes are one-cycle pulses on the core clock.
`default_nettype none
`include "pmra_consts.svh"

module pmra_event_flag
  import pmra_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_latch,
  input  wire logic i_upd,
  input  wire logic i_cond,
  input  wire logic i_rd_clr,
  input  wire logic i_ext_clr,
  output logic      o_flag
);

  logic flag_r;
  logic flag_nxt;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    flag_nxt = flag_r;
    if (i_latch) begin
      // set wins over a clear landing in the same cycle
      flag_nxt = (i_upd & i_cond) | (flag_r & ~(i_rd_clr | i_ext_clr));  // (R5)
    end else if (i_upd) begin
      flag_nxt = i_cond;  // (R4)
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign o_flag = flag_r;

endmodule

`default_nettype wire

// File: logic/pmra_result_regs.sv
// pmra_result_regs.sv: temperature, current and power result holding
// registers.
// assumes: values are stable while i_upd is high.
`default_nettype none
`include "pmra_consts.svh"

module pmra_result_regs
  import pmra_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_upd,
  input  wire logic [11:0] i_temp,
  input  wire logic [15:0] i_curr,
  input  wire logic [23:0] i_pwr,
  output pmra_word_t       o_temp,
  output pmra_word_t       o_curr,
  output logic [23:0]      o_pwr
);

  logic [11:0] temp_r;
  logic [11:0] temp_nxt;
  logic [15:0] curr_r;
  logic [15:0] curr_nxt;
  logic [23:0] pwr_r;
  logic [23:0] pwr_nxt;

  // ----------------------------------------
  // capture
  // ----------------------------------------
  always_comb begin
    temp_nxt = temp_r;
    curr_nxt = curr_r;
    pwr_nxt  = pwr_r;
    if (i_upd) begin
      temp_nxt = i_temp;
      curr_nxt = i_curr;  // (R2)
      pwr_nxt  = i_pwr;   // (R3)
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      temp_r <= 12'h000;
      curr_r <= 16'h0000;
      pwr_r  <= `PMRA_RESULT_RST;
    end else begin
      temp_r <= temp_nxt;
      curr_r <= curr_nxt;
      pwr_r  <= pwr_nxt;
    end
  end

  // low nibble of the temperature word is hard zero
  assign o_temp = {temp_r, 4'h0};  // (R1)
  assign o_curr = curr_r;
  assign o_pwr  = pwr_r;

endmodule

`default_nettype wire

// File: logic/pmra_top.sv
// pmra_top.sv: result registers, diagnostic flags and alert pin driver
// of the power monitor.
// assumes: the serial port and the conversion sequencer run on the same
// core clock and hand over one-cycle strobes; the alert pad resolves
// the open-drain wire from o_ALERT_O and O_ALERT_OE_N.
`default_nettype none
`include "pmra_consts.svh"

module pmra_top
  import pmra_pkg::*;
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  // register port from the serial engine
  input  wire logic [5:0]  I_REG_ADDR,
  input  wire logic        I_REG_RD,
  input  wire logic        I_REG_WR,
  input  wire logic [15:0] I_REG_WDATA,
  output logic [23:0]      O_REG_RDATA,
  output logic             O_REG_RVALID,
  // conversion sequencer
  input  wire logic [3:0]  I_MODE,
  input  wire logic [2:0]  I_AVERAGING_COUNT,
  input  wire logic        I_CONV_START,
  input  wire logic        I_CONV_DONE,
  input  wire logic        I_SAMPLE_VALID,
  input  wire logic        I_AVERAGE_DONE,
  input  wire logic [11:0] I_TEMP_VALUE,
  input  wire logic [15:0] I_CURRENT_VALUE,
  input  wire logic [23:0] I_POWER_VALUE,
  input  wire logic [5:0]  I_LIMIT_COND,
  input  wire logic        I_MATH_OVF,
  input  wire logic        I_ACC_CLEAR,
  input  wire logic        I_TRIM_CSUM_ERR,
  // open-drain alert pin
  output logic             O_ALERT_O,
  output logic             O_ALERT_OE_N
);

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  function automatic pmra_mode_t mode_class(input logic [3:0] m);
    pmra_mode_t c;
    case (m)
      4'h0, 4'h8: c = PMRA_MODE_OFF;  // (R21)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: c = PMRA_MODE_TRIG;  // (R21)
      default: c = PMRA_MODE_CONT;  // (R21)
    endcase
    return c;
  endfunction

  function automatic logic addr_hit(input logic [5:0] a, input logic [5:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic       alert_latch_enable_r;
  logic       alert_latch_enable_nxt;
  logic       ready_on_alert_enable_r;
  logic       ready_on_alert_enable_nxt;
  logic       averaged_compare_select_r;
  logic       averaged_compare_select_nxt;
  logic       alert_polarity_select_r;
  logic       alert_polarity_select_nxt;
  logic       math_overflow_flag_r;
  logic       math_overflow_flag_nxt;
  logic       trim_checksum_ok_r;
  logic       trim_checksum_ok_nxt;
  logic [23:0] rdata_r;
  logic [23:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;
  logic       alert_drive_r;
  logic       alert_drive_nxt;
  logic       alert_level_r;
  logic       alert_level_nxt;

  logic       diag_wr;
  logic       diag_rd;
  logic       trig_start;
  logic       cmp_strobe;
  logic       result_upd;
  logic [5:0] limit_flags;
  logic       conversion_done_flag;
  logic       alert_active;
  pmra_word_t diagnostic_reg;
  pmra_word_t die_temp_value;
  pmra_word_t current_word;
  logic [23:0] power_word;

  // ----------------------------------------
  // strobes
  // ----------------------------------------
  assign diag_wr    = I_REG_WR & addr_hit(I_REG_ADDR, `PMRA_OFS_DIAG);
  assign diag_rd    = I_REG_RD & addr_hit(I_REG_ADDR, `PMRA_OFS_DIAG);
  // only a start in a single-shot mode counts as a new triggered conversion
  assign trig_start = I_CONV_START & (mode_class(I_MODE) == PMRA_MODE_TRIG);  // (R21)
  // averaged compare delays the alert to the end of the averaging run
  assign cmp_strobe = averaged_compare_select_r ? I_AVERAGE_DONE : I_SAMPLE_VALID;  // (R7)
  // with averaging off every sample is a finished result
  assign result_upd = (I_AVERAGING_COUNT == 3'h0) ? I_SAMPLE_VALID : I_AVERAGE_DONE;  // (R20)

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  pmra_result_regs u_results (
    .i_clk  (I_CORE_CLK),
    .i_rst  (I_RST),
    .i_upd  (result_upd),
    .i_temp (I_TEMP_VALUE),
    .i_curr (I_CURRENT_VALUE),
    .i_pwr  (I_POWER_VALUE),
    .o_temp (die_temp_value),
    .o_curr (current_word),
    .o_pwr  (power_word)
  );

  // ----------------------------------------
  // limit event flags, diagnostic bits 7..2
  // ----------------------------------------
  // index 0 power, 1 bus under, 2 bus over, 3 shunt under, 4 shunt over,
  // 5 temperature over
  for (genvar g = 0; g < `PMRA_NUM_LIMITS; g++) begin : g_lim
    pmra_event_flag u_flag (
      .i_clk     (I_CORE_CLK),
      .i_rst     (I_RST),
      .i_latch   (alert_latch_enable_r),
      .i_upd     (cmp_strobe),
      .i_cond    (I_LIMIT_COND[g]),  // (R12) (R13) (R14) (R15) (R16) (R17)
      .i_rd_clr  (diag_rd),
      .i_ext_clr (1'b0),
      .o_flag    (limit_flags[g])
    );
  end

  // ----------------------------------------
  // conversion done flag, diagnostic bit 1
  // ----------------------------------------
  // transparent mode drops it when the next conversion starts
  pmra_event_flag u_done (
    .i_clk     (I_CORE_CLK),
    .i_rst     (I_RST),
    .i_latch   (alert_latch_enable_r),
    .i_upd     (I_CONV_DONE | I_CONV_START),
    .i_cond    (I_CONV_DONE),
    .i_rd_clr  (diag_rd),
    .i_ext_clr (trig_start),  // (R18)
    .o_flag    (conversion_done_flag)
  );

  // ----------------------------------------
  // configuration and sticky status
  // ----------------------------------------
  always_comb begin
    alert_latch_enable_nxt      = alert_latch_enable_r;
    ready_on_alert_enable_nxt   = ready_on_alert_enable_r;
    averaged_compare_select_nxt = averaged_compare_select_r;
    alert_polarity_select_nxt   = alert_polarity_select_r;
    if (diag_wr) begin
      alert_latch_enable_nxt      = I_REG_WDATA[`PMRA_BIT_LATCH];
      ready_on_alert_enable_nxt   = I_REG_WDATA[`PMRA_BIT_RDYALERT];
      averaged_compare_select_nxt = I_REG_WDATA[`PMRA_BIT_AVGCMP];
      alert_polarity_select_nxt   = I_REG_WDATA[`PMRA_BIT_POLSEL];
    end
    // overflow stays until a new trigger or accumulator clear; set wins
    math_overflow_flag_nxt = I_MATH_OVF |
                             (math_overflow_flag_r & ~(trig_start | I_ACC_CLEAR));  // (R10) (R11)
    // checksum failure is permanent until reset
    trim_checksum_ok_nxt = trim_checksum_ok_r & ~I_TRIM_CSUM_ERR;  // (R19)
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      alert_latch_enable_r      <= 1'(`PMRA_DIAG_RST >> `PMRA_BIT_LATCH);
      ready_on_alert_enable_r   <= 1'b0;
      averaged_compare_select_r <= 1'b0;
      alert_polarity_select_r   <= 1'b0;
      math_overflow_flag_r      <= 1'b0;
      trim_checksum_ok_r        <= 1'b1;  // (R19)
    end else begin
      alert_latch_enable_r      <= alert_latch_enable_nxt;
      ready_on_alert_enable_r   <= ready_on_alert_enable_nxt;
      averaged_compare_select_r <= averaged_compare_select_nxt;
      alert_polarity_select_r   <= alert_polarity_select_nxt;
      math_overflow_flag_r      <= math_overflow_flag_nxt;
      trim_checksum_ok_r        <= trim_checksum_ok_nxt;
    end
  end

  // ----------------------------------------
  // diagnostic word
  // ----------------------------------------
  always_comb begin
    diagnostic_reg = 16'h0000;  // (R9)
    diagnostic_reg[`PMRA_BIT_LATCH]    = alert_latch_enable_r;
    diagnostic_reg[`PMRA_BIT_RDYALERT] = ready_on_alert_enable_r;
    diagnostic_reg[`PMRA_BIT_AVGCMP]   = averaged_compare_select_r;
    diagnostic_reg[`PMRA_BIT_POLSEL]   = alert_polarity_select_r;
    diagnostic_reg[`PMRA_BIT_OVF]      = math_overflow_flag_r;
    diagnostic_reg[`PMRA_BIT_LIMLO +: `PMRA_NUM_LIMITS] = limit_flags;
    diagnostic_reg[`PMRA_BIT_DONE]     = conversion_done_flag;
    diagnostic_reg[`PMRA_BIT_TRIMOK]   = trim_checksum_ok_r;
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // data is sampled before the read-clear lands, so the host sees the event
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = I_REG_RD;
    if (I_REG_RD) begin
      case (I_REG_ADDR)
        `PMRA_OFS_TEMP: rdata_nxt = {8'h00, die_temp_value};  // (R1)
        `PMRA_OFS_CURR: rdata_nxt = {8'h00, current_word};  // (R2)
        `PMRA_OFS_PWR:  rdata_nxt = power_word;  // (R3)
        `PMRA_OFS_DIAG: rdata_nxt = {8'h00, diagnostic_reg};
        default:        rdata_nxt = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_r  <= 24'h000000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign O_REG_RDATA  = rdata_r;
  assign O_REG_RVALID = rvalid_r;

  // ----------------------------------------
  // alert pin
  // ----------------------------------------
  assign alert_active = (|limit_flags) |
                        (ready_on_alert_enable_r & conversion_done_flag);  // (R6) (R22)

  always_comb begin
    // open drain: only the active level is ever driven
    alert_drive_nxt = alert_active;  // (R4) (R5) (R22)
    alert_level_nxt = alert_polarity_select_r;  // (R8)
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      alert_drive_r <= 1'b0;
      alert_level_r <= 1'b0;
    end else begin
      alert_drive_r <= alert_drive_nxt;
      alert_level_r <= alert_level_nxt;
    end
  end

  assign O_ALERT_O    = alert_level_r;
  assign O_ALERT_OE_N = ~alert_drive_r;

endmodule

`default_nettype wire

// File: bench/pmra_host_model.sv
// pmra_host_model.sv: serial-port host that reads and writes the bank.
// assumes: register strobes are one-cycle pulses on the core clock.
`default_nettype none

module pmra_host_model
  import pmra_pkg::*;
(
  input  wire logic  i_clk,
  output logic [5:0] o_addr,
  output logic       o_rd,
  output logic       o_wr,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // register cycles
  // ----------------------------------------
  initial begin
    o_addr  = 6'h00;
    o_rd    = 1'b0;
    o_wr    = 1'b0;
    o_wdata = 16'h0000;
  end
  // released lines show the inverse, so a stale index never passes
  task automatic rd(input logic [5:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask
endmodule

`default_nettype wire

// File: bench/pmra_properties.sv
// pmra_properties.sv: port assertions of the result and alert bank.
// assumes: bound to pmra_top; config bits 15-12 are mirrored from writes.
`default_nettype none
`include "pmra_consts.svh"

module pmra_checker
  import pmra_pkg::*;
(
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST,
  input wire logic [5:0]  I_REG_ADDR,
  input wire logic        I_REG_RD,
  input wire logic        I_REG_WR,
  input wire logic [15:0] I_REG_WDATA,
  input wire logic [23:0] O_REG_RDATA,
  input wire logic        O_REG_RVALID,
  input wire logic        I_SAMPLE_VALID,
  input wire logic        I_AVERAGE_DONE,
  input wire logic        I_CONV_DONE,
  input wire logic [5:0]  I_LIMIT_COND,
  input wire logic        O_ALERT_O,
  input wire logic        O_ALERT_OE_N
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // config mirror and properties
  // ----------------------------------------
  logic [3:0] cfg_r;
  logic [3:0] cfg_nxt;
  always_comb begin
    cfg_nxt = cfg_r;
    if (I_REG_WR && I_REG_ADDR == `PMRA_OFS_DIAG) begin
      cfg_nxt = I_REG_WDATA[15:12];
    end
  end
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      cfg_r <= 4'h0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  sequence s_rd(logic [5:0] a);
    I_REG_RD && I_REG_ADDR == a;
  endsequence
  // pin active under latching, with no read to clear it
  sequence s_held;
    (cfg_r[3] && !cfg_r[2] && !I_REG_RD) ##1 (cfg_r[3] && !cfg_r[2] && !O_ALERT_OE_N);
  endsequence

  a_temp_low_zero: assert property (s_rd(`PMRA_OFS_TEMP) |=> O_REG_RVALID && O_REG_RDATA[3:0] == 4'h0)
    else $error("temperature low bits set");
  a_reserved_read_zero: assert property (s_rd(`PMRA_OFS_DIAG) |=> O_REG_RDATA[11:10] == 2'b00 && !O_REG_RDATA[8])
    else $error("reserved diagnostic bits set");
  a_transparent_release: assert property ((cfg_r[3:1] == 3'b000 && I_SAMPLE_VALID && I_LIMIT_COND == 6'h00 &&
    !I_REG_WR) |-> ##2 O_ALERT_OE_N) else $error("alert kept after fault went");
  a_latched_alert_hold: assert property (s_held |=> !O_ALERT_OE_N)
    else $error("latched alert dropped without a read");
  a_ready_alert: assert property (cfg_r[2] && I_CONV_DONE && !I_REG_WR |-> ##2 !O_ALERT_OE_N)
    else $error("conversion done not on alert");
  a_raw_limit_alert: assert property (!cfg_r[1] && I_SAMPLE_VALID && |I_LIMIT_COND |-> ##2 !O_ALERT_OE_N)
    else $error("limit event not on alert");
  a_averaged_limit_alert: assert property (cfg_r[1] && I_AVERAGE_DONE && |I_LIMIT_COND |-> ##2 !O_ALERT_OE_N)
    else $error("averaged limit event not on alert");
  a_drive_polarity: assert property (!O_ALERT_OE_N |-> O_ALERT_O == $past(cfg_r[0]))
    else $error("alert driven at wrong level");
endmodule

bind pmra_top pmra_checker pmra_checker_inst (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_RD(I_REG_RD), .I_REG_WR(I_REG_WR), .I_REG_WDATA(I_REG_WDATA),
  .O_REG_RDATA(O_REG_RDATA), .O_REG_RVALID(O_REG_RVALID), .I_SAMPLE_VALID(I_SAMPLE_VALID),
  .I_AVERAGE_DONE(I_AVERAGE_DONE), .I_CONV_DONE(I_CONV_DONE), .I_LIMIT_COND(I_LIMIT_COND),
  .O_ALERT_O(O_ALERT_O), .O_ALERT_OE_N(O_ALERT_OE_N));

`default_nettype wire

// File: bench/testbench.sv
// testbench.sv: self-checking bench of the result and alert bank.
// assumes: the host model drives the register port; strobes come from here.
`default_nettype none
`include "pmra_consts.svh"

module testbench
  import pmra_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // stimulus and scoreboard
  // ----------------------------------------
  localparam logic [6:0] SV = 7'h01, AVD = 7'h02, DN = 7'h04, ST = 7'h08, OV = 7'h10, AC = 7'h20, TR = 7'h40;
  localparam logic [5:0] DG = `PMRA_OFS_DIAG;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [6:0]  stb = 7'h00;
  logic [5:0]  cond = 6'h00;
  logic [3:0]  mode = 4'h0;
  logic [2:0]  avgc = 3'h0;
  logic [11:0] tv = 12'h000;
  logic [15:0] cv = 16'h0000;
  logic [23:0] pv = 24'h000000;
  logic [23:0] pv0;
  logic [5:0]  addr;
  logic        rd;
  logic        wr;
  logic [15:0] wdata;
  logic [23:0] rdata;
  logic        rvalid;
  logic        al_o;
  logic        al_oe_n;
  logic [23:0] q[$];
  int          bad_count = 0;
  int          checked = 0;
  int          seed = 42;

  pmra_host_model pmra_host_model_inst (.i_clk(clk), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
  pmra_top pmra_top_inst (.I_CORE_CLK(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_RD(rd), .I_REG_WR(wr),
    .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_MODE(mode), .I_AVERAGING_COUNT(avgc),
    .I_CONV_START(stb[3]), .I_CONV_DONE(stb[2]), .I_SAMPLE_VALID(stb[0]), .I_AVERAGE_DONE(stb[1]),
    .I_TEMP_VALUE(tv), .I_CURRENT_VALUE(cv), .I_POWER_VALUE(pv), .I_LIMIT_COND(cond),
    .I_MATH_OVF(stb[4]), .I_ACC_CLEAR(stb[5]), .I_TRIM_CSUM_ERR(stb[6]), .O_ALERT_O(al_o),
    .O_ALERT_OE_N(al_oe_n));

  always #12.5 clk = ~clk;

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdx(input logic [5:0] a, input logic [23:0] e);
    q.push_back(e);
    pmra_host_model_inst.rd(a);
  endtask
  task automatic wrx(input logic [5:0] a, input logic [15:0] d);
    pmra_host_model_inst.wr(a, d);
  endtask
  task automatic fire(input logic [6:0] s, input logic [5:0] c);
    @(posedge clk);
    stb  <= s;
    cond <= c;
    @(posedge clk);
    stb  <= 7'h00;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    if (q.size() != 0) bad_count++;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // an answer with no note pending counts as a mismatch; an unknown valid is not taken as an answer
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (q.size() > 0) begin
        chk(rdata, q.pop_front());
      end else begin
        bad_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, rdata, 24'h000000);
      end
    end
  end

  // whole run is a few hundred cycles, so this leaves ample margin
  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdx(`PMRA_OFS_TEMP, 24'h000000);
    rdx(`PMRA_OFS_CURR, 24'h000000);
    rdx(`PMRA_OFS_PWR, 24'h000000);
    rdx(DG, 24'h000001);
    rdx(6'h3f, 24'h000000);
    wrx(`PMRA_OFS_TEMP, 16'hffff);
    wrx(DG, 16'hffff);
    rdx(`PMRA_OFS_TEMP, 24'h000000);
    rdx(DG, 24'h00f001);
    wrx(DG, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      tv <= 12'($random(seed));
      cv <= 16'($random(seed));
      pv <= 24'($random(seed));
      fire(SV, 6'h00);
      rdx(`PMRA_OFS_TEMP, {8'h00, tv, 4'h0});
      rdx(`PMRA_OFS_CURR, {8'h00, cv});
      rdx(`PMRA_OFS_PWR, pv);
    end
    avgc <= 3'h3;
    pv0 = pv;
    pv <= 24'($random(seed));
    fire(SV, 6'h00);
    rdx(`PMRA_OFS_PWR, pv0);
    fire(AVD, 6'h00);
    rdx(`PMRA_OFS_PWR, pv);
    for (int i = 0; i < 6; i++) begin
      fire(SV, 6'(1 << i));
      settle(2);
      chk({22'h0, al_oe_n, al_o}, 24'h000000);
      rdx(DG, 24'(16'h0001 | (16'h0004 << i)));
    end
    fire(SV, 6'h00);
    settle(2);
    chk({23'h0, al_oe_n}, 24'h000001);
    rdx(DG, 24'h000001);
    wrx(DG, 16'h9000);
    fire(SV, 6'h20);
    fire(SV, 6'h00);
    settle(2);
    chk({22'h0, al_oe_n, al_o}, 24'h000001);
    rdx(DG, 24'h009081);
    rdx(DG, 24'h009001);
    settle(3);
    chk({23'h0, al_oe_n}, 24'h000001);
    wrx(DG, 16'hc000);
    fire(DN, 6'h00);
    settle(2);
    chk({22'h0, al_oe_n, al_o}, 24'h000000);
    rdx(DG, 24'h00c003);
    rdx(DG, 24'h00c001);
    mode <= 4'h1;
    fire(DN, 6'h00);
    fire(ST, 6'h00);
    rdx(DG, 24'h00c001);
    wrx(DG, 16'h8000);
    fire(DN, 6'h00);
    settle(2);
    chk({23'h0, al_oe_n}, 24'h000001);
    rdx(DG, 24'h008003);
    wrx(DG, 16'h2000);
    fire(SV, 6'h01);
    rdx(DG, 24'h002001);
    fire(AVD, 6'h01);
    rdx(DG, 24'h002005);
    fire(AVD, 6'h00);
    wrx(DG, 16'h0000);
    for (int m = 0; m < 16; m++) begin
      mode <= 4'(m);
      fire(OV, 6'h00);
      rdx(DG, 24'h000201);
      fire(ST, 6'h00);
      rdx(DG, (m >= 1 && m <= 7) ? 24'h000001 : 24'h000201);
    end
    fire(AC, 6'h00);
    rdx(DG, 24'h000001);
    fire(TR, 6'h00);
    rdx(DG, 24'h000000);
    fire(AC, 6'h00);
    rdx(DG, 24'h000000);
    settle(3);
    conclude();
  end
endmodule

`default_nettype wire
